// File: hdl/rcr_top.sv
// regulator control register bank behind the serial slave's byte port
// Function
// - the six registers sit at 0x0b..0x0f and 0x1c and every bit reads and writes.
// - power-up loads 2.85 V and 3.3 V fixed codes and 1.25, 2.75, 2.81 V steps.
// - enable bit 2 picks the card supply level, 0 for 3.0 V and 1 for 1.80 V.
// - the fixed-step register holds discharge bits 7 and 3 and codes 6..4, 2..0.
// - each adjustable register holds discharge in bit 7 and a 7-bit step code.
// - the third adjustable register at 0x0f has that layout, default 2.81 V.
// - enable bits 7..3, 1 and 0 switch five regulators, card supply and rtc.
// - a regulator that is off with its discharge bit set grounds its output.
// - step codes map 0 to 1.224 V, 1 to 1.250 V, 127 to 4.463 V, about 25 mV.
`timescale 1ns/10ps
`include "rcr_params.svh"
module rcr_top
   import rcr_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic [4:0] reg_on_out,
   output logic [4:0] discharge_out,
   output logic card_supply_on_out,
   output logic card_supply_level_out,
   output logic rtc_on_out,
   output logic fixed_reg_on_out,
   output logic [2:0] reg_a_code_out,
   output logic [2:0] reg_b_code_out,
   output logic [6:0] reg_c_code_out,
   output logic [6:0] reg_d_code_out,
   output logic [6:0] reg_e_code_out
);
   // ---------------------------------------------
   // address decode
   // ---------------------------------------------
   // returns {hit, index}; shared by the write and read paths
   function automatic logic [3:0] addr_decode(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h0;
      case (a)
         `RCR_ADDR_EN: r = {1'b1, `RCR_IDX_EN};
         `RCR_ADDR_FSV: r = {1'b1, `RCR_IDX_FSV};
         `RCR_ADDR_ADJ_A: r = {1'b1, `RCR_IDX_ADJ_A};
         `RCR_ADDR_ADJ_B: r = {1'b1, `RCR_IDX_ADJ_B};
         `RCR_ADDR_ADJ_C: r = {1'b1, `RCR_IDX_ADJ_C};
         `RCR_ADDR_GP3: r = {1'b1, `RCR_IDX_GP3};
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   rcr_byte_t mem_r [`RCR_NREG];
   rcr_byte_t mem_nxt [`RCR_NREG];
   rcr_byte_t rdata_r, rdata_nxt;
   logic [3:0] dec;
   logic hit;
   rcr_idx_t idx;

   assign dec = addr_decode(reg_addr_in);
   assign hit = dec[3];
   assign idx = dec[2:0];

   // ---------------------------------------------
   // register storage
   // ---------------------------------------------
   always_comb
   begin
      for (int i = 0; i < `RCR_NREG; i++)
         mem_nxt[i] = mem_r[i];
      // every bit writable; unmapped writes are dropped
      if (reg_wr_in && hit)
         mem_nxt[idx] = reg_wdata_in;
      rdata_nxt = rdata_r;
      // every bit reads back, unmapped reads give zero
      if (reg_rd_in)
         rdata_nxt = hit ? mem_r[idx] : `RCR_RDATA_NONE;
   end

   // power-up defaults loaded by reset
   // the step codes 0x01, 0x3c and 0x3e sit nearest 1.25, 2.75 and 2.81 V
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mem_r[`RCR_IDX_EN] <= `RCR_RST_EN;
         mem_r[`RCR_IDX_FSV] <= `RCR_RST_FSV;
         mem_r[`RCR_IDX_ADJ_A] <= `RCR_RST_ADJ_A;
         mem_r[`RCR_IDX_ADJ_B] <= `RCR_RST_ADJ_B;
         mem_r[`RCR_IDX_ADJ_C] <= `RCR_RST_ADJ_C;
         mem_r[`RCR_IDX_GP3] <= `RCR_RST_GP3;
         rdata_r <= `RCR_RDATA_NONE;
      end
      else
      begin
         for (int i = 0; i < `RCR_NREG; i++)
            mem_r[i] <= mem_nxt[i];
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_out = rdata_r;

   // ---------------------------------------------
   // field decode
   // ---------------------------------------------
   // the step code goes to the analog ladder unchanged
   rcr_ctl_if ctl ();
   assign ctl.en = mem_r[`RCR_IDX_EN];
   assign ctl.fsv = mem_r[`RCR_IDX_FSV];
   assign ctl.adj_a = mem_r[`RCR_IDX_ADJ_A];
   assign ctl.adj_b = mem_r[`RCR_IDX_ADJ_B];
   assign ctl.adj_c = mem_r[`RCR_IDX_ADJ_C];
   // other bits are stored for readback only
   assign ctl.gp3 = mem_r[`RCR_IDX_GP3];

   rcr_outdec u_dec (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .ctl(ctl),
      .reg_on_out(reg_on_out),
      .discharge_out(discharge_out),
      .card_supply_on_out(card_supply_on_out),
      .card_supply_level_out(card_supply_level_out),
      .rtc_on_out(rtc_on_out),
      .fixed_reg_on_out(fixed_reg_on_out),
      .reg_a_code_out(reg_a_code_out),
      .reg_b_code_out(reg_b_code_out),
      .reg_c_code_out(reg_c_code_out),
      .reg_d_code_out(reg_d_code_out),
      .reg_e_code_out(reg_e_code_out)
   );
endmodule // rcr_top

// File: pkg/rcr_params.svh
// constants for the regulator control register bank
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH
// ---------------------------------------------
// register addresses
// ---------------------------------------------
`define RCR_ADDR_EN 8'h0b
`define RCR_ADDR_FSV 8'h0c
`define RCR_ADDR_ADJ_A 8'h0d
`define RCR_ADDR_ADJ_B 8'h0e
`define RCR_ADDR_ADJ_C 8'h0f
`define RCR_ADDR_GP3 8'h1c
// ---------------------------------------------
// storage indices
// ---------------------------------------------
`define RCR_NREG 6
`define RCR_IDX_EN 3'h0
`define RCR_IDX_FSV 3'h1
`define RCR_IDX_ADJ_A 3'h2
`define RCR_IDX_ADJ_B 3'h3
`define RCR_IDX_ADJ_C 3'h4
`define RCR_IDX_GP3 3'h5
// ---------------------------------------------
// power-up values
// ---------------------------------------------
`define RCR_RST_EN 8'hfd
`define RCR_RST_FSV 8'hcf
`define RCR_RST_ADJ_A 8'h81
`define RCR_RST_ADJ_B 8'hbc
`define RCR_RST_ADJ_C 8'hbe
`define RCR_RST_GP3 8'h00
`define RCR_RDATA_NONE 8'h00
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define RCR_EN_REGS_HI 7
`define RCR_EN_REGS_LO 3
`define RCR_EN_CARD_LEVEL 2
`define RCR_EN_CARD_ON 1
`define RCR_EN_RTC_ON 0
`define RCR_FSV_A_DIS 7
`define RCR_FSV_A_HI 6
`define RCR_FSV_A_LO 4
`define RCR_FSV_B_DIS 3
`define RCR_FSV_B_HI 2
`define RCR_FSV_B_LO 0
`define RCR_ADJ_DIS 7
`define RCR_ADJ_HI 6
`define RCR_ADJ_LO 0
`define RCR_GP3_FIXED_ON 5
`endif

// File: pkg/rcr_pkg.sv
// types shared by the regulator control register bank
package rcr_pkg;
   typedef logic [7:0] rcr_byte_t;
   typedef logic [2:0] rcr_idx_t;
   typedef logic [2:0] rcr_fcode_t;
   typedef logic [6:0] rcr_acode_t;
endpackage

// File: pkg/rcr_ctl_if.sv
// register contents passed from the bank to the output decoder
`timescale 1ns/10ps
interface rcr_ctl_if;
   import rcr_pkg::*;
   rcr_byte_t en;
   rcr_byte_t fsv;
   rcr_byte_t adj_a;
   rcr_byte_t adj_b;
   rcr_byte_t adj_c;
   rcr_byte_t gp3;
   modport src (output en, fsv, adj_a, adj_b, adj_c, gp3);
   modport dec (input en, fsv, adj_a, adj_b, adj_c, gp3);
endinterface

// File: hdl/rcr_outdec.sv
// registered decode of register fields onto regulator controls
`timescale 1ns/10ps
`include "rcr_params.svh"
module rcr_outdec
   import rcr_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   rcr_ctl_if.dec ctl,
   output logic [4:0] reg_on_out,
   output logic [4:0] discharge_out,
   output logic card_supply_on_out,
   output logic card_supply_level_out,
   output logic rtc_on_out,
   output logic fixed_reg_on_out,
   output rcr_fcode_t reg_a_code_out,
   output rcr_fcode_t reg_b_code_out,
   output rcr_acode_t reg_c_code_out,
   output rcr_acode_t reg_d_code_out,
   output rcr_acode_t reg_e_code_out
);
   logic [4:0] on_r, on_nxt;
   logic [4:0] dis_r, dis_nxt;
   logic [4:0] dis_en;
   logic card_on_r, card_on_nxt;
   logic card_lvl_r, card_lvl_nxt;
   logic rtc_r, rtc_nxt;
   logic fixed_r, fixed_nxt;
   rcr_fcode_t a_r, a_nxt, b_r, b_nxt;
   rcr_acode_t c_r, c_nxt, d_r, d_nxt, e_r, e_nxt;
   // power-up output values follow from the register defaults
   localparam rcr_byte_t pu_en = `RCR_RST_EN;
   localparam rcr_byte_t pu_fsv = `RCR_RST_FSV;
   localparam rcr_byte_t pu_adj_a = `RCR_RST_ADJ_A;
   localparam rcr_byte_t pu_adj_b = `RCR_RST_ADJ_B;
   localparam rcr_byte_t pu_adj_c = `RCR_RST_ADJ_C;
   localparam rcr_byte_t pu_gp3 = `RCR_RST_GP3;
   localparam logic [4:0] pu_dis = {pu_fsv[`RCR_FSV_A_DIS],
      pu_fsv[`RCR_FSV_B_DIS], pu_adj_a[`RCR_ADJ_DIS],
      pu_adj_b[`RCR_ADJ_DIS], pu_adj_c[`RCR_ADJ_DIS]}
      & ~pu_en[`RCR_EN_REGS_HI:`RCR_EN_REGS_LO];

   // ---------------------------------------------
   // field decode
   // ---------------------------------------------
   always_comb
   begin
      on_nxt = ctl.en[`RCR_EN_REGS_HI:`RCR_EN_REGS_LO];
      card_on_nxt = ctl.en[`RCR_EN_CARD_ON];
      rtc_nxt = ctl.en[`RCR_EN_RTC_ON];
      card_lvl_nxt = ctl.en[`RCR_EN_CARD_LEVEL];
      a_nxt = ctl.fsv[`RCR_FSV_A_HI:`RCR_FSV_A_LO];
      b_nxt = ctl.fsv[`RCR_FSV_B_HI:`RCR_FSV_B_LO];
      c_nxt = ctl.adj_a[`RCR_ADJ_HI:`RCR_ADJ_LO];
      d_nxt = ctl.adj_b[`RCR_ADJ_HI:`RCR_ADJ_LO];
      e_nxt = ctl.adj_c[`RCR_ADJ_HI:`RCR_ADJ_LO];
      // discharge enables, bit order a..e from msb
      dis_en = {ctl.fsv[`RCR_FSV_A_DIS], ctl.fsv[`RCR_FSV_B_DIS],
                ctl.adj_a[`RCR_ADJ_DIS], ctl.adj_b[`RCR_ADJ_DIS],
                ctl.adj_c[`RCR_ADJ_DIS]};
      // pull output down only while off and enabled
      dis_nxt = dis_en & ~on_nxt;
      // only this bit of the general register acts
      fixed_nxt = ctl.gp3[`RCR_GP3_FIXED_ON];
   end

   // ---------------------------------------------
   // output registers
   // ---------------------------------------------
   // reset values match the power-up register contents
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         on_r <= pu_en[`RCR_EN_REGS_HI:`RCR_EN_REGS_LO];
         dis_r <= pu_dis;
         card_on_r <= pu_en[`RCR_EN_CARD_ON];
         card_lvl_r <= pu_en[`RCR_EN_CARD_LEVEL];
         rtc_r <= pu_en[`RCR_EN_RTC_ON];
         fixed_r <= pu_gp3[`RCR_GP3_FIXED_ON];
         a_r <= pu_fsv[`RCR_FSV_A_HI:`RCR_FSV_A_LO];
         b_r <= pu_fsv[`RCR_FSV_B_HI:`RCR_FSV_B_LO];
         c_r <= pu_adj_a[`RCR_ADJ_HI:`RCR_ADJ_LO];
         d_r <= pu_adj_b[`RCR_ADJ_HI:`RCR_ADJ_LO];
         e_r <= pu_adj_c[`RCR_ADJ_HI:`RCR_ADJ_LO];
      end
      else
      begin
         on_r <= on_nxt;
         dis_r <= dis_nxt;
         card_on_r <= card_on_nxt;
         card_lvl_r <= card_lvl_nxt;
         rtc_r <= rtc_nxt;
         fixed_r <= fixed_nxt;
         a_r <= a_nxt;
         b_r <= b_nxt;
         c_r <= c_nxt;
         d_r <= d_nxt;
         e_r <= e_nxt;
      end
   end

   assign reg_on_out = on_r;
   assign discharge_out = dis_r;
   assign card_supply_on_out = card_on_r;
   assign card_supply_level_out = card_lvl_r;
   assign rtc_on_out = rtc_r;
   assign fixed_reg_on_out = fixed_r;
   assign reg_a_code_out = a_r;
   assign reg_b_code_out = b_r;
   assign reg_c_code_out = c_r;
   assign reg_d_code_out = d_r;
   assign reg_e_code_out = e_r;
endmodule // rcr_outdec

// File: tb/rcr_host.sv
// host model driving the byte register port of the bank
`timescale 1ns/10ps
module rcr_host
(
   input wire logic mclk_in,
   input wire logic [7:0] rdata_in,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial
   begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge mclk_in);
      wr_out = 1'b0;
      // stale data must not look valid
      wdata_out = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge mclk_in);
      rd_out = 1'b0;
      d = rdata_in;
   endtask
endmodule // rcr_host

// File: tb/rcr_checker.sv
// port checks for the register bank
`timescale 1ns/10ps
module rcr_checker
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [4:0] reg_on_out,
   input wire logic [4:0] discharge_out,
   input wire logic card_supply_on_out,
   input wire logic card_supply_level_out,
   input wire logic rtc_on_out,
   input wire logic fixed_reg_on_out,
   input wire logic [2:0] reg_a_code_out,
   input wire logic [2:0] reg_b_code_out,
   input wire logic [6:0] reg_c_code_out,
   input wire logic [6:0] reg_d_code_out,
   input wire logic [6:0] reg_e_code_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   logic w_en;
   logic w_fsv;
   logic w_adj;
   logic w_gp;
   assign w_en = reg_wr_in && reg_addr_in == 8'h0b;
   assign w_fsv = reg_wr_in && reg_addr_in == 8'h0c;
   assign w_adj = reg_wr_in && reg_addr_in == 8'h0f;
   assign w_gp = reg_wr_in && reg_addr_in == 8'h1c;
   a_enable_write: assert property (w_en |=> ##1 {reg_on_out,
      card_supply_level_out, card_supply_on_out, rtc_on_out}
      == $past(reg_wdata_in, 2)) else $error("enable outputs wrong");
   a_fixed_codes: assert property (w_fsv |=> ##1 {reg_a_code_out,
      reg_b_code_out} == {$past(reg_wdata_in[6:4], 2),
      $past(reg_wdata_in[2:0], 2)}) else $error("fixed codes wrong");
   a_adj_code: assert property (w_adj |=> ##1 reg_e_code_out
      == $past(reg_wdata_in[6:0], 2)) else $error("step code wrong");
   a_fixed_on: assert property (w_gp |=> ##1 fixed_reg_on_out
      == $past(reg_wdata_in[5], 2)) else $error("fixed enable wrong");
   a_discharge_off: assert property ((discharge_out & reg_on_out)
      == 5'h00) else $error("discharge on a running regulator");
   a_discharge_write: assert property (w_fsv |=> ##1
      discharge_out[4] == ($past(reg_wdata_in[7], 2) && !reg_on_out[4]))
      else $error("discharge of regulator a wrong");
   a_unmapped_read: assert property (reg_rd_in && !(reg_addr_in
      inside {8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h1c})
      |=> reg_rdata_out == 8'h00) else $error("unmapped read not 0");
   a_rdata_hold: assert property (!reg_rd_in |=>
      $stable(reg_rdata_out)) else $error("read data moved");
   a_ctl_hold: assert property (!reg_wr_in |=> ##1 $stable({
      reg_on_out, fixed_reg_on_out, reg_c_code_out, reg_d_code_out}))
      else $error("controls moved without write");
   cover property (w_en);
   cover property (discharge_out != 5'h00);
   cover property (reg_rd_in && reg_addr_in == 8'h10);
endmodule // rcr_checker
bind rcr_top rcr_checker i_chk (.*);

// File: tb/regulator_control_registers_test.sv
// self-checking bench for the regulator control register bank
`timescale 1ns/10ps
`include "rcr_params.svh"
module regulator_control_registers_test;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
   logic reg_wr_in, reg_rd_in, card_supply_on_out, card_supply_level_out;
   logic rtc_on_out, fixed_reg_on_out;
   logic [4:0] reg_on_out, discharge_out;
   logic [2:0] reg_a_code_out, reg_b_code_out;
   logic [6:0] reg_c_code_out, reg_d_code_out, reg_e_code_out;
   logic [7:0] addrs [6] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h1c};
   int n_mismatch = 0;
   int checked = 0;
   always #20 mclk_in = ~mclk_in;
   rcr_top i_dut (.*);
   rcr_host i_host (.mclk_in(mclk_in), .rdata_in(reg_rdata_out),
      .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
      .wr_out(reg_wr_in), .rd_out(reg_rd_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // controls settle one rising edge after the write edge
   task automatic wrs(input logic [7:0] a, input logic [7:0] v);
      i_host.wr(a, v);
      @(negedge mclk_in);
   endtask
   task automatic t_defaults;
      logic [7:0] rv [6] = '{`RCR_RST_EN, `RCR_RST_FSV, `RCR_RST_ADJ_A,
         `RCR_RST_ADJ_B, `RCR_RST_ADJ_C, `RCR_RST_GP3};
      chk({reg_on_out, discharge_out[2:0]}, 8'hf8);
      chk({2'h0, reg_a_code_out, reg_b_code_out}, 8'h27);
      chk({reg_c_code_out, card_supply_level_out}, 8'h03);
      chk({reg_d_code_out, rtc_on_out}, 8'h79);
      chk({1'b0, reg_e_code_out}, 8'h3e);
      foreach (addrs[i])
      begin
         i_host.rd(addrs[i], d);
         chk(d, rv[i]);
      end
      $display("defaults done");
   endtask
   task automatic t_readback;
      foreach (addrs[i])
      begin
         i_host.wr(addrs[i], 8'h5a ^ addrs[i]);
         i_host.rd(addrs[i], d);
         chk(d, 8'h5a ^ addrs[i]);
      end
      i_host.wr(8'h10, 8'hff);
      i_host.rd(8'h10, d);
      chk(d, 8'h00);
      i_host.rd(8'h0b, d);
      chk(d, 8'h5a ^ 8'h0b);
      $display("readback done");
   endtask
   task automatic t_fields;
      wrs(8'h0c, 8'hc7);
      wrs(8'h0d, 8'h80);
      wrs(8'h0e, 8'h81);
      wrs(8'h0f, 8'h7f);
      wrs(8'h0b, 8'ha6);
      chk({2'h0, reg_a_code_out, reg_b_code_out}, 8'h27);
      chk({5'h00, card_supply_level_out, card_supply_on_out,
         rtc_on_out}, 8'h06);
      chk({3'h0, reg_on_out}, 8'h14);
      chk({3'h0, discharge_out}, 8'h02);
      chk({reg_c_code_out, reg_d_code_out[0]}, 8'h01);
      chk({1'b0, reg_e_code_out}, 8'h7f);
      wrs(8'h1c, 8'hdf);
      chk({2'h0, fixed_reg_on_out, reg_on_out}, 8'h14);
      wrs(8'h1c, 8'h20);
      chk({7'h00, fixed_reg_on_out}, 8'h01);
      $display("fields done");
   endtask
   // a mid-run reset must bring back the power-up settings
   task automatic t_reset;
      @(negedge mclk_in);
      rst_in = 1'b1;
      @(negedge mclk_in);
      rst_in = 1'b0;
      chk({3'h0, reg_on_out}, 8'h1f);
      chk({7'h00, fixed_reg_on_out}, 8'h00);
      i_host.rd(`RCR_ADDR_FSV, d);
      chk(d, `RCR_RST_FSV);
      $display("reset done");
   endtask
   task automatic give_verdict;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: a stuck run counts as a mismatch
   initial
   begin
      repeat (3000) @(posedge mclk_in);
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      repeat (4) @(negedge mclk_in);
      rst_in = 1'b0;
      t_defaults();
      t_readback();
      t_fields();
      t_reset();
      give_verdict();
   end
endmodule // regulator_control_registers_test
